// file: core/frf_pkg.sv
// shared constants and types of the banked floating-point register file
package frf_pkg;

  // storage geometry
  localparam int unsigned WORD_W     = 32;   // one physical register
  localparam int unsigned BANK_REGS  = 16;   // registers per bank
  localparam int unsigned PHYS_REGS  = 32;   // both banks together
  localparam int unsigned PHYS_AW    = 5;    // {bank, index}
  localparam int unsigned VIEW_W     = 128;  // widest view (four words)

  // register bus
  localparam int unsigned REG_AW     = 8;
  localparam logic [7:0]  OFS_FPSC   = 8'h00; // status/control word
  localparam logic [7:0]  OFS_IRQ_ST = 8'h04; // sticky event status
  localparam logic [7:0]  OFS_IRQ_MK = 8'h08; // event mask

  // status/control field positions
  localparam int unsigned POS_BANK_SWAP  = 21;
  localparam int unsigned POS_PAIR_SIZE  = 20;
  localparam int unsigned POS_DBL_PREC   = 19;
  localparam int unsigned POS_DENORM     = 18;
  localparam int unsigned POS_CAUSE_LO   = 12;
  localparam int unsigned POS_CAUSE_HI   = 17;
  localparam int unsigned POS_ENABLE_LO  = 7;
  localparam int unsigned POS_ENABLE_HI  = 11;
  localparam int unsigned POS_FLAG_LO    = 2;
  localparam int unsigned POS_FLAG_HI    = 6;
  localparam int unsigned POS_ROUND_LO   = 0;
  localparam int unsigned POS_ROUND_HI   = 1;

  // status/control value after reset and writable bits
  localparam logic [31:0] FPSC_RESET     = 32'h0004_0001;
  localparam logic [31:0] FPSC_WR_MASK   = 32'h003F_FFFF;
  localparam logic [31:0] FPSC_RSVD_MASK = 32'hFFC0_0000;

  // exception cause lanes (error, invalid, div0, ovf, unf, inexact)
  localparam int unsigned CAUSE_W  = 6;
  localparam int unsigned FLAG_W   = 5;

  // interrupt event bits
  localparam int unsigned IRQ_W        = 3;
  localparam int unsigned IRQ_EXC      = 0; // an operation raised a cause
  localparam int unsigned IRQ_SWAP     = 1; // bank mapping changed
  localparam int unsigned IRQ_RSVD_WR  = 2; // nonzero write to reserved bits
  localparam logic [2:0]  IRQ_RESET    = 3'h0;

  // rounding encodings
  localparam logic [1:0]  RND_NEAREST  = 2'h0;
  localparam logic [1:0]  RND_ZERO     = 2'h1;

  // view selection of the pipeline read port
  typedef enum logic [2:0] {
    VIEW_SINGLE,
    VIEW_DOUBLE,
    VIEW_VECTOR,
    VIEW_XSINGLE,
    VIEW_XDOUBLE,
    VIEW_XCOLUMN,
    VIEW_XROW
  } frf_view_e;

endpackage : frf_pkg

// file: core/frf_store.sv
// physical storage of both banks, two word write ports
`timescale 1ns/1ps
`default_nettype none
module frf_store
  import frf_pkg::*;
(
  // clock and reset
  input  wire logic                          i_core_clk,
  input  wire logic                          i_reset_n,
  // first write word
  input  wire logic                          i_w0_en,
  input  wire logic [PHYS_AW-1:0]            i_w0_addr,
  input  wire logic [WORD_W-1:0]             i_w0_data,
  // second write word (pair low half)
  input  wire logic                          i_w1_en,
  input  wire logic [PHYS_AW-1:0]            i_w1_addr,
  input  wire logic [WORD_W-1:0]             i_w1_data,
  // every physical word, index {bank, reg}
  output logic      [PHYS_REGS-1:0][WORD_W-1:0] o_words
);

  logic [PHYS_REGS-1:0][WORD_W-1:0] mem_q; // one flop word per entry

  // one flop word per physical register
  genvar g;
  generate
    for (g = 0; g < PHYS_REGS; g++)
    begin : g_entry
      // the two ports never aim at one word; port 0 wins anyway
      always_ff @(posedge i_core_clk)
      begin
        if (!i_reset_n)
          mem_q[g] <= 32'h0000_0000;
        else if (i_w0_en && (i_w0_addr == PHYS_AW'(g)))
          mem_q[g] <= i_w0_data;
        else if (i_w1_en && (i_w1_addr == PHYS_AW'(g)))
          mem_q[g] <= i_w1_data;
      end
    end
  endgenerate

  assign o_words = mem_q;

endmodule : frf_store
`default_nettype wire

// file: core/frf_status.sv
// status/control word with exception cause and flag tracking
`timescale 1ns/1ps
`default_nettype none
module frf_status
  import frf_pkg::*;
(
  // clock and reset
  input  wire logic                i_core_clk,
  input  wire logic                i_reset_n,
  // software write
  input  wire logic                i_wr_en,
  input  wire logic [31:0]         i_wr_data,
  // operation completion
  input  wire logic                i_op_valid,
  input  wire logic [CAUSE_W-1:0]  i_op_cause,
  // current word
  output logic      [31:0]         o_value
);

  logic [31:0] value_q; // held word
  logic [31:0] value_d; // next word

  // software write first, operation effects layered on top
  always_comb
  begin
    value_d = value_q;
    if (i_wr_en)
      value_d = i_wr_data & FPSC_WR_MASK;
    if (i_op_valid)
    begin
      value_d[POS_CAUSE_HI:POS_CAUSE_LO] = i_op_cause;
      value_d[POS_FLAG_HI:POS_FLAG_LO] =
        value_d[POS_FLAG_HI:POS_FLAG_LO] | i_op_cause[FLAG_W-1:0];
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
      value_q <= FPSC_RESET;
    else
      value_q <= value_d;
  end

  assign o_value = value_q;

endmodule : frf_status
`default_nettype wire

// file: core/frf_top.sv
// banked floating-point register file with status/control word
//
// Behaviour
// - thirty-two words, two banks of sixteen
// - bank swap picks primary single bank
// - extended views use the other bank
// - double view joins singles n, n+1
// - vector view is four consecutive singles
// - extended double joins extended n, n+1
// - extended sixteen form 4x4 matrix
// - bits 31..22 reserved, read zero
// - bank swap bit 21, resets zero
// - bit 20 selects 32 or 64-bit moves
// - bit 19 selects double precision
// - bit 18 flushes denormals, resets one
// - rounding bits 1:0 reset to 01
// - cause cleared per op, flags sticky
`timescale 1ns/1ps
`default_nettype none
module frf_top
  import frf_pkg::*;
(
  // clock and reset
  input  wire logic                i_core_clk,
  input  wire logic                i_reset_n,
  // register bus
  input  wire logic [REG_AW-1:0]   i_reg_addr,
  input  wire logic [31:0]         i_reg_wdata,
  input  wire logic                i_reg_wr,
  input  wire logic                i_reg_rd,
  output logic      [31:0]         o_reg_rdata,
  // pipeline read port
  input  wire logic                i_rd_en,
  input  wire frf_view_e           i_rd_view,
  input  wire logic                i_rd_move,
  input  wire logic [3:0]          i_rd_index,
  output logic      [VIEW_W-1:0]   o_rd_data,
  output logic                     o_rd_valid,
  // pipeline write port
  input  wire logic                i_wr_en,
  input  wire logic                i_wr_ext,
  input  wire logic                i_wr_pair,
  input  wire logic                i_wr_move,
  input  wire logic [3:0]          i_wr_index,
  input  wire logic [63:0]         i_wr_data,
  // operation completion
  input  wire logic                i_op_valid,
  input  wire logic [CAUSE_W-1:0]  i_op_cause,
  // mode outputs toward the datapath
  output logic                     o_bank_swap,
  output logic                     o_transfer_pair_size,
  output logic                     o_double_precision_select,
  output logic                     o_denorm_flush,
  output logic      [1:0]          o_rounding_select,
  output logic      [FLAG_W-1:0]   o_exc_enable,
  // interrupt
  output logic                     o_irq
);

  // register decode
  logic                 sel_fpsc;     // address hits status/control
  logic                 sel_irq_st;   // address hits event status
  logic                 sel_irq_mk;   // address hits event mask
  logic                 fpsc_wr;      // software write to status/control

  // status/control word and its modes
  logic [31:0]          fpsc_val;     // current word from the leaf
  logic                 bank_swap;    // primary bank select
  logic                 pair_size;    // move width select

  // interrupt state
  logic [IRQ_W-1:0]     irq_stat_q;   // sticky events
  logic [IRQ_W-1:0]     irq_stat_d;
  logic [IRQ_W-1:0]     irq_mask_q;   // enable per event
  logic [IRQ_W-1:0]     irq_mask_d;
  logic [IRQ_W-1:0]     irq_event;    // events of this cycle
  logic                 irq_q;

  // bus read data
  logic [31:0]          reg_rdata_q;
  logic [31:0]          reg_rdata_d;

  // storage access
  logic [PHYS_REGS-1:0][WORD_W-1:0] words; // every physical word
  logic                 w0_en;
  logic [PHYS_AW-1:0]   w0_addr;
  logic [WORD_W-1:0]    w0_data;
  logic                 w1_en;
  logic [PHYS_AW-1:0]   w1_addr;
  logic [WORD_W-1:0]    w1_data;
  logic                 wr_bank;      // physical bank of the write
  logic                 wr_pair_eff;  // write carries two words

  // pipeline read
  logic [VIEW_W-1:0]    rd_data_q;
  logic [VIEW_W-1:0]    rd_data_d;
  logic                 rd_valid_q;
  logic                 bank_p;       // bank behind primary views
  logic                 bank_x;       // bank behind extended views

  // address decoding
  always_comb
  begin
    sel_fpsc   = 1'b0;
    sel_irq_st = 1'b0;
    sel_irq_mk = 1'b0;
    if (i_reg_addr == OFS_FPSC)
      sel_fpsc = 1'b1;
    else if (i_reg_addr == OFS_IRQ_ST)
      sel_irq_st = 1'b1;
    else if (i_reg_addr == OFS_IRQ_MK)
      sel_irq_mk = 1'b1;
  end

  assign fpsc_wr = i_reg_wr & sel_fpsc;

  // status/control word, cause and flag handling inside
  frf_status u_status (
    .i_core_clk (i_core_clk),
    .i_reset_n  (i_reset_n),
    .i_wr_en    (fpsc_wr),
    .i_wr_data  (i_reg_wdata),
    .i_op_valid (i_op_valid),
    .i_op_cause (i_op_cause),
    .o_value    (fpsc_val)
  );

  assign bank_swap = fpsc_val[POS_BANK_SWAP];
  assign pair_size = fpsc_val[POS_PAIR_SIZE];

  // mode outputs straight from the stored word
  assign o_bank_swap               = bank_swap;
  assign o_transfer_pair_size      = pair_size;
  assign o_double_precision_select = fpsc_val[POS_DBL_PREC];
  assign o_denorm_flush            = fpsc_val[POS_DENORM];
  assign o_rounding_select         = fpsc_val[POS_ROUND_HI:POS_ROUND_LO];
  assign o_exc_enable              = fpsc_val[POS_ENABLE_HI:POS_ENABLE_LO];

  // events of this cycle
  always_comb
  begin
    irq_event = '0;
    // an operation that raised any cause
    irq_event[IRQ_EXC] = i_op_valid & (|i_op_cause);
    // a write that flips the bank mapping
    irq_event[IRQ_SWAP] = fpsc_wr &
      (i_reg_wdata[POS_BANK_SWAP] != bank_swap);
    irq_event[IRQ_RSVD_WR] = fpsc_wr & (|(i_reg_wdata & FPSC_RSVD_MASK));
  end

  // read of status clears it, but a new event wins over the clear
  always_comb
  begin
    irq_stat_d = irq_stat_q;
    if (i_reg_rd && sel_irq_st)
      irq_stat_d = '0;
    irq_stat_d = irq_stat_d | irq_event;
  end

  // mask written whole
  always_comb
  begin
    irq_mask_d = irq_mask_q;
    if (i_reg_wr && sel_irq_mk)
      irq_mask_d = i_reg_wdata[IRQ_W-1:0];
  end

  // interrupt registers
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      irq_stat_q <= IRQ_RESET;
      irq_mask_q <= IRQ_RESET;
      irq_q      <= 1'b0;
    end
    else
    begin
      irq_stat_q <= irq_stat_d;
      irq_mask_q <= irq_mask_d;
      // built from next values so the line tracks the flops exactly
      irq_q      <= |(irq_stat_d & irq_mask_d);
    end
  end

  // bus read mux, unmapped addresses answer zero
  always_comb
  begin
    reg_rdata_d = 32'h0000_0000;
    if (sel_fpsc)
      // reserved bits held zero in the leaf
      reg_rdata_d = fpsc_val & FPSC_WR_MASK;
    else if (sel_irq_st)
      reg_rdata_d = {29'h0, irq_stat_q};
    else if (sel_irq_mk)
      reg_rdata_d = {29'h0, irq_mask_q};
  end

  // read data stand for one cycle after the strobe only
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
      reg_rdata_q <= 32'h0000_0000;
    else if (i_reg_rd)
      reg_rdata_q <= reg_rdata_d;
    else
      reg_rdata_q <= 32'h0000_0000;
  end

  // primary bank follows the swap bit
  assign bank_p = bank_swap;
  // extended views on the other bank
  assign bank_x = ~bank_swap;

  // write mapping: logical view to physical words
  always_comb
  begin
    // stored bit only, so a swap write acts from the next cycle
    wr_bank     = i_wr_ext ? bank_x : bank_p;
    // moves carry a pair while set
    wr_pair_eff = i_wr_pair | (i_wr_move & pair_size);
    w0_en       = i_wr_en;
    w1_en       = 1'b0;
    w0_addr     = {wr_bank, i_wr_index};
    w0_data     = i_wr_data[31:0];
    w1_addr     = {wr_bank, i_wr_index};
    w1_data     = i_wr_data[31:0];
    if (wr_pair_eff)
    begin
      // even word high half, odd low
      w0_addr = {wr_bank, i_wr_index[3:1], 1'b0};
      w0_data = i_wr_data[63:32];
      w1_en   = i_wr_en;
      w1_addr = {wr_bank, i_wr_index[3:1], 1'b1};
    end
  end

  frf_store u_store (
    .i_core_clk (i_core_clk),
    .i_reset_n  (i_reset_n),
    .i_w0_en    (w0_en),
    .i_w0_addr  (w0_addr),
    .i_w0_data  (w0_data),
    .i_w1_en    (w1_en),
    .i_w1_addr  (w1_addr),
    .i_w1_data  (w1_data),
    .o_words    (words)
  );

  // pick one word of a bank
  function automatic logic [31:0] pick(input logic bank,
                                       input logic [3:0] idx);
    pick = words[{bank, idx}];
  endfunction : pick

  // view assembly; lower-numbered word sits in the upper bits
  always_comb
  begin
    rd_data_d = '0;
    case (i_rd_view)
      VIEW_SINGLE:
      begin
        if (i_rd_move && pair_size)
          rd_data_d[63:0] = {pick(bank_p, {i_rd_index[3:1], 1'b0}),
                             pick(bank_p, {i_rd_index[3:1], 1'b1})};
        else
          rd_data_d[31:0] = pick(bank_p, i_rd_index);
      end
      VIEW_DOUBLE:
        rd_data_d[63:0] = {pick(bank_p, {i_rd_index[3:1], 1'b0}),
                           pick(bank_p, {i_rd_index[3:1], 1'b1})};
      VIEW_VECTOR:
        rd_data_d = {pick(bank_p, {i_rd_index[3:2], 2'h0}),
                     pick(bank_p, {i_rd_index[3:2], 2'h1}),
                     pick(bank_p, {i_rd_index[3:2], 2'h2}),
                     pick(bank_p, {i_rd_index[3:2], 2'h3})};
      VIEW_XSINGLE:
      begin
        if (i_rd_move && pair_size)
          rd_data_d[63:0] = {pick(bank_x, {i_rd_index[3:1], 1'b0}),
                             pick(bank_x, {i_rd_index[3:1], 1'b1})};
        else
          rd_data_d[31:0] = pick(bank_x, i_rd_index);
      end
      VIEW_XDOUBLE:
        rd_data_d[63:0] = {pick(bank_x, {i_rd_index[3:1], 1'b0}),
                           pick(bank_x, {i_rd_index[3:1], 1'b1})};
      VIEW_XCOLUMN:
        rd_data_d = {pick(bank_x, {i_rd_index[1:0], 2'h0}),
                     pick(bank_x, {i_rd_index[1:0], 2'h1}),
                     pick(bank_x, {i_rd_index[1:0], 2'h2}),
                     pick(bank_x, {i_rd_index[1:0], 2'h3})};
      VIEW_XROW:
        // row r: r, r+4, r+8, r+12
        rd_data_d = {pick(bank_x, {2'h0, i_rd_index[1:0]}),
                     pick(bank_x, {2'h1, i_rd_index[1:0]}),
                     pick(bank_x, {2'h2, i_rd_index[1:0]}),
                     pick(bank_x, {2'h3, i_rd_index[1:0]})};
      default:
        rd_data_d = '0;
    endcase
  end

  // registered read answer, held until the next read
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      rd_data_q  <= '0;
      rd_valid_q <= 1'b0;
    end
    else
    begin
      rd_valid_q <= i_rd_en;
      if (i_rd_en)
        rd_data_q <= rd_data_d;
    end
  end

  // outputs
  assign o_reg_rdata = reg_rdata_q;
  assign o_rd_data   = rd_data_q;
  assign o_rd_valid  = rd_valid_q;
  assign o_irq       = irq_q;

endmodule : frf_top
`default_nettype wire

// file: sim/frf_sva.sv
// port checker of the banked floating-point register file
`timescale 1ns/1ps
`default_nettype none
module frf_sva
  import frf_pkg::*;
(
  // clock and reset
  input wire logic              i_core_clk,
  input wire logic              i_reset_n,
  // register bus
  input wire logic [REG_AW-1:0] i_reg_addr,
  input wire logic [31:0]       i_reg_wdata,
  input wire logic              i_reg_wr,
  input wire logic              i_reg_rd,
  input wire logic [31:0]       o_reg_rdata,
  // pipeline read
  input wire logic              i_rd_en,
  input wire logic [VIEW_W-1:0] o_rd_data,
  input wire logic              o_rd_valid,
  // mode outputs
  input wire logic              o_bank_swap,
  input wire logic              o_transfer_pair_size,
  input wire logic              o_double_precision_select,
  input wire logic              o_denorm_flush,
  input wire logic [1:0]        o_rounding_select,
  input wire logic [FLAG_W-1:0] o_exc_enable
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);
  // mode bits in the order they sit in the word
  logic [10:0] mode;
  assign mode = {o_bank_swap, o_transfer_pair_size,
                 o_double_precision_select, o_denorm_flush,
                 o_exc_enable, o_rounding_select};
  // bus write aimed at the status/control word
  sequence s_ctl_wr;
    i_reg_wr && i_reg_addr == OFS_FPSC;
  endsequence
  // view read taken, answered one cycle on
  sequence s_view_rd;
    i_rd_en ##1 o_rd_valid;
  endsequence
  property p_rsvd_zero;
    o_reg_rdata[31:22] == 10'h000;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("reserved bits read nonzero");
  property p_rd_valid;
    i_rd_en |-> s_view_rd;
  endproperty
  a_rd_valid: assert property (p_rd_valid)
    else $error("view read not answered");
  property p_rd_quiet;
    !i_rd_en |=> !o_rd_valid;
  endproperty
  a_rd_quiet: assert property (p_rd_quiet)
    else $error("view valid without request");
  property p_data_hold;
    !i_rd_en |=> $stable(o_rd_data);
  endproperty
  a_data_hold: assert property (p_data_hold)
    else $error("view data moved without request");
  property p_rdata_idle;
    !i_reg_rd |=> o_reg_rdata == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("bus data outside read answer");
  // hazard: a stale field would leave the datapath in the old mode
  property p_mode_write;
    s_ctl_wr |=> mode == {$past(i_reg_wdata[21:18]),
                          $past(i_reg_wdata[11:7]), $past(i_reg_wdata[1:0])};
  endproperty
  a_mode_write: assert property (p_mode_write)
    else $error("mode outputs differ from written word");
  property p_mode_hold;
    !(i_reg_wr && i_reg_addr == OFS_FPSC) |=> $stable(mode);
  endproperty
  a_mode_hold: assert property (p_mode_hold)
    else $error("mode changed without a write");
  // reset itself is the cause here, so never disabled
  property p_reset_vals;
    disable iff (1'h0)
    !i_reset_n |=> mode == 11'h081 && !o_rd_valid;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("wrong mode after reset");
endmodule : frf_sva
bind frf_top frf_sva frf_sva_inst (.i_core_clk, .i_reset_n, .i_reg_addr,
  .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata, .i_rd_en, .o_rd_data,
  .o_rd_valid, .o_bank_swap, .o_transfer_pair_size,
  .o_double_precision_select, .o_denorm_flush, .o_rounding_select,
  .o_exc_enable);
`default_nettype wire

// file: sim/frf_core_model.sv
// behavioural core pipeline facing the register file
`timescale 1ns/1ps
`default_nettype none
module frf_core_model
  import frf_pkg::*;
(
  // clock and read answer
  input  wire logic               i_core_clk,
  input  wire logic [VIEW_W-1:0]  i_rd_data,
  input  wire logic               i_rd_valid,
  // read request
  output logic                    o_rd_en,
  output var frf_view_e           o_rd_view,
  output logic                    o_rd_move,
  output logic      [3:0]         o_rd_index,
  // write request
  output logic                    o_wr_en,
  output logic                    o_wr_ext,
  output logic                    o_wr_pair,
  output logic                    o_wr_move,
  output logic      [3:0]         o_wr_index,
  output logic      [63:0]        o_wr_data,
  // operation completion
  output logic                    o_op_valid,
  output logic      [CAUSE_W-1:0] o_op_cause
);
  // idle at time zero
  initial
  begin
    {o_rd_en, o_rd_move, o_rd_index, o_wr_en, o_wr_ext, o_wr_pair} = '0;
    {o_wr_move, o_wr_index, o_wr_data, o_op_valid, o_op_cause} = '0;
    o_rd_view = VIEW_SINGLE;
  end
  // one write, held up to its taking edge
  task automatic put(input logic x, p, m, input logic [3:0] i,
                     input logic [63:0] d);
    @(posedge i_core_clk);
    o_wr_en    <= 1'h1;
    o_wr_ext   <= x;
    o_wr_pair  <= p;
    o_wr_move  <= m;
    o_wr_index <= i;
    o_wr_data  <= d;
    @(posedge i_core_clk);
    o_wr_en    <= 1'h0;
    // released data must not look still valid
    o_wr_data  <= ~d;
  endtask : put
  // one view read, answer awaited under a bound
  task automatic get(input frf_view_e v, input logic m,
                     input logic [3:0] i, output logic [VIEW_W-1:0] d,
                     output logic ok);
    int n;
    ok = 1'h0;
    d  = '0;
    @(posedge i_core_clk);
    o_rd_en    <= 1'h1;
    o_rd_view  <= v;
    o_rd_move  <= m;
    o_rd_index <= i;
    @(posedge i_core_clk);
    o_rd_en    <= 1'h0;
    for (n = 0; n < 3 && !ok; n++)
    begin
      #1;
      ok = (i_rd_valid === 1'h1);
      d  = i_rd_data;
      if (!ok)
        @(posedge i_core_clk);
    end
  endtask : get
  // one completed operation with its cause lanes
  task automatic op(input logic [CAUSE_W-1:0] c);
    @(posedge i_core_clk);
    o_op_valid <= 1'h1;
    o_op_cause <= c;
    @(posedge i_core_clk);
    o_op_valid <= 1'h0;
    o_op_cause <= ~c;
  endtask : op
endmodule : frf_core_model
`default_nettype wire

// file: sim/testbench.sv
// self-checking bench of the banked register file
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import frf_pkg::*;
  // clock, reset, register bus
  logic         clk, rst_n, wr, rd;
  logic [7:0]   addr;
  logic [31:0]  wdat, rdat;
  // pipeline wires and design outputs
  logic         rd_en, rd_move, rd_valid, wr_en, wr_ext, wr_pair, wr_move;
  logic         op_valid, irq, sw, ps, dp, dn;
  frf_view_e    rd_view;
  logic [3:0]   rd_index, wr_index;
  logic [63:0]  wr_data;
  logic [127:0] rd_data;
  logic [5:0]   op_cause;
  logic [1:0]   rm;
  logic [4:0]   en;
  logic [10:0]  mode;
  int           fails, compares;
  assign mode = {sw, ps, dp, dn, en, rm};
  frf_top frf_top_inst (
    .i_core_clk(clk), .i_reset_n(rst_n), .i_reg_addr(addr),
    .i_reg_wdata(wdat), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdat),
    .i_rd_en(rd_en), .i_rd_view(rd_view), .i_rd_move(rd_move),
    .i_rd_index(rd_index), .o_rd_data(rd_data), .o_rd_valid(rd_valid),
    .i_wr_en(wr_en), .i_wr_ext(wr_ext), .i_wr_pair(wr_pair),
    .i_wr_move(wr_move), .i_wr_index(wr_index), .i_wr_data(wr_data),
    .i_op_valid(op_valid), .i_op_cause(op_cause), .o_bank_swap(sw),
    .o_transfer_pair_size(ps), .o_double_precision_select(dp),
    .o_denorm_flush(dn), .o_rounding_select(rm), .o_exc_enable(en),
    .o_irq(irq));
  frf_core_model frf_core_model_inst (
    .i_core_clk(clk), .i_rd_data(rd_data), .i_rd_valid(rd_valid),
    .o_rd_en(rd_en), .o_rd_view(rd_view), .o_rd_move(rd_move),
    .o_rd_index(rd_index), .o_wr_en(wr_en), .o_wr_ext(wr_ext),
    .o_wr_pair(wr_pair), .o_wr_move(wr_move), .o_wr_index(wr_index),
    .o_wr_data(wr_data), .o_op_valid(op_valid), .o_op_cause(op_cause));
  // 25 MHz core clock
  initial
  begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  task automatic complete_run;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : complete_run
  // bus word and view comparisons
  task automatic cw(input string n, input logic [31:0] e, g);
    compares++;
    if (g !== e)
    begin
      fails++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask : cw
  task automatic cv(input string n, input logic [127:0] e, g);
    compares++;
    if (g !== e)
    begin
      fails++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask : cv
  // bus write; settles one step past the taking edge
  task automatic bw(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr   <= 1'h1;
    addr <= a;
    wdat <= d;
    @(posedge clk);
    wr   <= 1'h0;
    #1;
  endtask : bw
  // bus read; data stands only the cycle after the strobe
  task automatic bc(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    rd   <= 1'h1;
    addr <= a;
    @(posedge clk);
    rd   <= 1'h0;
    #1;
    cw($sformatf("reg %h", a), e, rdat);
  endtask : bc
  // pattern word i of bank b, and four of them at stride st
  function automatic logic [31:0] wv(input logic b, input int i);
    return {b ? 4'h2 : 4'h1, 24'h00_0000, i[3:0]};
  endfunction : wv
  function automatic logic [127:0] quad(input logic b, input int i, st);
    return {wv(b, i), wv(b, i + st), wv(b, i + 2 * st), wv(b, i + 3 * st)};
  endfunction : quad
  task automatic vc(input frf_view_e v, input logic m, input int i,
                    input logic [127:0] e);
    logic [127:0] d;
    logic         ok;
    frf_core_model_inst.get(v, m, i[3:0], d, ok);
    if (!ok)
    begin
      fails++;
      complete_run();
    end
    else
      cv(v.name(), e, d);
  endtask : vc
  task automatic t_status;
    bc(OFS_FPSC, 32'h0004_0001);
    cw("mode", 32'h081, {21'h0, mode});
    bc(OFS_IRQ_MK, 32'h0);
    bc(8'h0C, 32'h0);
    bw(OFS_FPSC, 32'hFFFF_FFFF);
    bc(OFS_FPSC, 32'h003F_FFFF);
    cw("mode", 32'h7FF, {21'h0, mode});
    bw(OFS_FPSC, 32'h0028_0002);
    cw("mode", 32'h502, {21'h0, mode});
    bw(8'h0C, 32'h1234_5678);
    bc(8'h0C, 32'h0);
    bw(OFS_FPSC, 32'h0004_0001);
    $display("status test done");
  endtask : t_status
  task automatic t_views(input logic s);
    for (int i = 0; i < 16; i++)
    begin
      vc(VIEW_SINGLE, 1'h0, i, {96'h0, wv(s, i)});
      vc(VIEW_XSINGLE, 1'h0, i, {96'h0, wv(!s, i)});
      if (i % 2 == 0)
      begin
        vc(VIEW_DOUBLE, 1'h0, i, {64'h0, wv(s, i), wv(s, i + 1)});
        vc(VIEW_XDOUBLE, 1'h0, i, {64'h0, wv(!s, i), wv(!s, i + 1)});
      end
      if (i % 4 == 0)
        vc(VIEW_VECTOR, 1'h0, i, quad(s, i, 1));
      if (i < 4)
      begin
        vc(VIEW_XCOLUMN, 1'h0, i, quad(!s, 4 * i, 1));
        vc(VIEW_XROW, 1'h0, i, quad(!s, i, 4));
      end
    end
    $display("views test done, swap %0d", s);
  endtask : t_views
  task automatic t_swap;
    // read taken with the swap write still sees the old bank
    fork
      bw(OFS_FPSC, 32'h0024_0001);
      vc(VIEW_VECTOR, 1'h0, 8, quad(1'h0, 8, 1));
    join
    bw(OFS_FPSC, 32'h0004_0001);
    // read taken the edge after the swap write
    fork
      bw(OFS_FPSC, 32'h0024_0001);
      begin
        @(posedge clk);
        vc(VIEW_VECTOR, 1'h0, 8, quad(1'h1, 8, 1));
      end
    join
    t_views(1'h1);
  endtask : t_swap
  task automatic t_pair;
    bw(OFS_FPSC, 32'h0014_0001);
    vc(VIEW_SINGLE, 1'h1, 6, {64'h0, wv(1'h0, 6), wv(1'h0, 7)});
    frf_core_model_inst.put(1'h0, 1'h0, 1'h1, 4'h5,
                            64'hAAAA_0001_BBBB_0002);
    vc(VIEW_DOUBLE, 1'h0, 4, {64'h0, 64'hAAAA_0001_BBBB_0002});
    bw(OFS_FPSC, 32'h0004_0001);
    frf_core_model_inst.put(1'h0, 1'h0, 1'h1, 4'h9,
                            64'hCCCC_0003_DDDD_0004);
    vc(VIEW_DOUBLE, 1'h0, 8, {64'h0, wv(1'h0, 8), 32'hDDDD_0004});
    $display("pair test done");
  endtask : t_pair
  task automatic t_exc;
    bc(OFS_IRQ_ST, 32'h6);
    bw(OFS_IRQ_MK, 32'h0000_0007);
    frf_core_model_inst.op(6'h3F);
    bc(OFS_FPSC, 32'h0007_F07D);
    cw("irq", 32'h1, {31'h0, irq});
    bc(OFS_IRQ_ST, 32'h1);
    repeat (2) @(posedge clk);
    #1;
    cw("irq", 32'h0, {31'h0, irq});
    frf_core_model_inst.op(6'h00);
    bc(OFS_FPSC, 32'h0004_007D);
    bw(OFS_IRQ_MK, 32'h0);
    bw(OFS_FPSC, 32'hFFE4_007D);
    cw("irq", 32'h0, {31'h0, irq});
    bc(OFS_IRQ_ST, 32'h6);
    $display("event test done");
  endtask : t_exc
  initial
  begin
    fails    = 0;
    compares = 0;
    {rst_n, wr, rd, addr, wdat} = '0;
    repeat (8) @(posedge clk);
    rst_n <= 1'h1;
    t_status();
    // pair writes fill both banks while swap is clear
    for (int i = 0; i < 16; i += 2)
    begin
      frf_core_model_inst.put(1'h0, 1'h1, 1'h0, i[3:0],
                              {wv(1'h0, i), wv(1'h0, i + 1)});
      frf_core_model_inst.put(1'h1, 1'h1, 1'h0, i[3:0],
                              {wv(1'h1, i), wv(1'h1, i + 1)});
    end
    t_views(1'h0);
    t_swap();
    t_pair();
    t_exc();
    complete_run();
  end
endmodule : testbench
`default_nettype wire
